// >>> design/enp_burst_qual.sv
// Purpose: Qualify received link codewords of one port before they are taken.
// Assumes: Bursts arrive as one-cycle strobes from logic on the same clock.
// Notes: Emits one pulse per accepted next page and holds the acknowledge level.
`timescale 1ns/1ps
`include "enp_map.svh"

module enp_burst_qual
    import enp_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    // Received bursts.
    input enp_burst_type burst_in,
    // Accepted page and acknowledge.
    output enp_page_type page_out,
    output logic ack_out
);

    enp_qual_state_type state_q;
    logic [15:0] last_q;
    logic [1:0] cnt_q;
    logic exp_tog_q;
    logic [15:0] masked_new;
    logic [15:0] masked_old;
    logic same;
    logic reached;
    logic tog_ok;

    // The acknowledge bit is left out of the comparison.
    assign masked_new = burst_in.word & ~`ENP_ACK_MASK;
    assign masked_old = last_q & ~`ENP_ACK_MASK;
    assign same = (cnt_q != 2'h0) && (masked_new == masked_old);
    assign reached = burst_in.valid && same && (cnt_q == (`ENP_CONSIST_CNT - 2'h1));
    // A next page must carry the toggle opposite to the previous codeword.
    assign tog_ok = (burst_in.word[`ENP_BIT_TOGGLE] == exp_tog_q);

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_q <= ENP_Q_BASE;
            last_q <= 16'h0000;
            cnt_q <= 2'h0;
            exp_tog_q <= 1'b0;
            page_out <= '0;
            ack_out <= 1'b0;
        end else begin
            page_out.valid <= 1'b0;
            if (burst_in.valid) begin
                last_q <= burst_in.word;
                if (!same) begin
                    cnt_q <= 2'h1;
                    ack_out <= 1'b0;
                end else if (cnt_q != `ENP_CONSIST_CNT) begin
                    cnt_q <= cnt_q + 2'h1;
                end
            end
            if (reached) begin
                ack_out <= 1'b1;
                if (burst_in.base) begin
                    // First next page toggle is the inverse of the base bit.
                    exp_tog_q <= ~burst_in.word[`ENP_BIT_TOGGLE];
                    state_q <= ENP_Q_NEXT;
                end else if (state_q == ENP_Q_NEXT && tog_ok) begin
                    page_out.valid <= 1'b1;
                    page_out.word <= burst_in.word;
                    exp_tog_q <= ~exp_tog_q;
                    if (!burst_in.word[`ENP_BIT_MORE]) begin
                        state_q <= ENP_Q_BASE;
                    end
                end
            end
        end
    end

endmodule // enp_burst_qual

// >>> design/enp_next_page_regs.sv
// Purpose: Indirect EEE register window holding the partner's received next page per port.
// Assumes: Register strobes and bursts come from logic on core_clk_in.
// Notes: Reads answer one cycle after the read strobe; unmapped reads return zero.
`timescale 1ns/1ps
`include "enp_map.svh"

module enp_next_page_regs
    import enp_pkg::*;
#(
    parameter int NUM_PORTS = 2,
    parameter logic [10:0] EEE_MSG_CODE = 11'h00A
)
(
    // Clock and reset.
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    // Register access.
    input enp_reg_req_type reg_req_in,
    output logic [7:0] reg_rdata_out,
    output logic reg_rvalid_out,
    // Per-port received bursts.
    input enp_burst_type burst_in [NUM_PORTS],
    // Per-port status toward the PHYs.
    output logic [NUM_PORTS-1:0] ack_out,
    output logic [NUM_PORTS-1:0] eee_100_en_out
);

    localparam int PIDX_W = (NUM_PORTS > 1) ? $clog2(NUM_PORTS) : 1;

    // The table select only addresses ports 3 and 4.
    generate
        if (NUM_PORTS != int'(`ENP_LAST_PORT - `ENP_FIRST_PORT) + 1) begin : g_bad_ports
            $error("NUM_PORTS must match the addressable port range.");
        end
    endgenerate

    // Direct registers.
    logic [7:0] tbl_sel_q;
    logic [7:0] ofs_q;
    logic [7:0] rdata_q;
    logic rvalid_q;

    // Per-port storage.
    logic [15:0] np_rx_q [NUM_PORTS];
    logic lp_eee_q [NUM_PORTS];
    logic local_adv_q [NUM_PORTS];
    logic hw_en_q [NUM_PORTS];
    logic hw_stat_q [NUM_PORTS];
    logic eee_en_q [NUM_PORTS];
    enp_neg_state_type neg_state_q [NUM_PORTS];
    logic [7:0] rd_byte [NUM_PORTS];
    enp_page_type page [NUM_PORTS];

    // Decode of the direct address space.
    wire tbl_wr = reg_req_in.wr && (reg_req_in.addr == `ENP_ADDR_TBL_SEL);
    wire ofs_wr = reg_req_in.wr && (reg_req_in.addr == `ENP_ADDR_OFFSET);
    wire data_hit = (reg_req_in.addr == `ENP_ADDR_DATA);

    // Window selection.
    wire [3:0] port_num = tbl_sel_q[`ENP_PORT_MSB:0];
    wire tbl_ok = (tbl_sel_q[`ENP_TBL_MSB:`ENP_TBL_LSB] == `ENP_TBL_EEE);
    wire port_ok = tbl_ok && (port_num >= `ENP_FIRST_PORT) &&
        (port_num <= `ENP_LAST_PORT);
    wire [3:0] port_off = port_num - `ENP_FIRST_PORT;
    wire [PIDX_W-1:0] port_idx = port_off[PIDX_W-1:0];
    wire data_wr = reg_req_in.wr && data_hit && port_ok;

    // A window outside the EEE table or the port range reads as zero.
    wire [7:0] win_byte = port_ok ? rd_byte[port_idx] : 8'h00;

    // Read data multiplexer; unmapped addresses answer zero.
    wire [7:0] rd_mux =
        (reg_req_in.addr == `ENP_ADDR_TBL_SEL) ? tbl_sel_q :
        (reg_req_in.addr == `ENP_ADDR_OFFSET) ? ofs_q :
        data_hit ? win_byte : 8'h00;

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            tbl_sel_q <= `ENP_RST_TBL_SEL;
            ofs_q <= `ENP_RST_OFFSET;
        end else begin
            if (tbl_wr) begin
                tbl_sel_q <= reg_req_in.wdata;
            end
            if (ofs_wr) begin
                ofs_q <= reg_req_in.wdata;
            end
        end
    end

    // Read answer is registered so the output comes straight from a flop.
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= reg_req_in.rd;
            if (reg_req_in.rd) begin
                rdata_q <= rd_mux;
            end
        end
    end

    assign reg_rdata_out = rdata_q;
    assign reg_rvalid_out = rvalid_q;

    genvar i;
    generate
        for (i = 0; i < NUM_PORTS; i++) begin : g_port

            // Qualifies bursts, tracks toggle order and drives the acknowledge.
            enp_burst_qual u_qual (
                .core_clk_in(core_clk_in),
                .reset_n_in(reset_n_in),
                .burst_in(burst_in[i]),
                .page_out(page[i]),
                .ack_out(ack_out[i])
            );

            wire sel = port_ok && (port_idx == PIDX_W'(i));
            wire wr_adv = data_wr && sel && (ofs_q == `ENP_OFS_ADV_LO);
            wire wr_ctl = data_wr && sel && (ofs_q == `ENP_OFS_CTL_LO);
            wire [15:0] pw = page[i].word;
            wire is_eee_msg = pw[`ENP_BIT_MSG] && (pw[`ENP_CODE_MSB:0] == EEE_MSG_CODE);
            wire is_cap_page = !pw[`ENP_BIT_MSG] && (neg_state_q[i] == ENP_NEG_WAIT_CAP);
            wire cap_take = page[i].valid && hw_en_q[i] && is_cap_page;
            wire cap_match = pw[`ENP_BIT_CAP_100] && local_adv_q[i];

            // Indirect byte view of this port's table.
            assign rd_byte[i] =
                (ofs_q == `ENP_OFS_NP_RX_HI) ? np_rx_q[i][15:8] :
                (ofs_q == `ENP_OFS_NP_RX_LO) ? np_rx_q[i][7:0] :
                (ofs_q == `ENP_OFS_ADV_HI) ?
                    {6'h00, lp_eee_q[i], 1'b0} :
                (ofs_q == `ENP_OFS_ADV_LO) ?
                    {6'h00, local_adv_q[i], 1'b0} :
                (ofs_q == `ENP_OFS_CTL_LO) ?
                    {hw_en_q[i], hw_stat_q[i], 5'h00, eee_en_q[i]} : 8'h00;

            // Whole codeword stored in one edge so fields never mix across pages.
            always_ff @(posedge core_clk_in or negedge reset_n_in) begin
                if (!reset_n_in) begin
                    np_rx_q[i] <= `ENP_RST_NP_RX;
                end else if (page[i].valid) begin
                    np_rx_q[i] <= page[i].word;
                end
            end

            // Software-owned advertisement and control bits.
            always_ff @(posedge core_clk_in or negedge reset_n_in) begin
                if (!reset_n_in) begin
                    local_adv_q[i] <= `ENP_RST_LOCAL_ADV;
                    hw_en_q[i] <= `ENP_RST_HW_EN;
                end else begin
                    if (wr_adv) begin
                        local_adv_q[i] <= reg_req_in.wdata[`ENP_BIT_CAP_100];
                    end
                    if (wr_ctl) begin
                        hw_en_q[i] <= reg_req_in.wdata[`ENP_BIT_CTL_HW_EN];
                    end
                end
            end

            // Hardware capability exchange: an EEE message page, then its capability page.
            always_ff @(posedge core_clk_in or negedge reset_n_in) begin
                if (!reset_n_in) begin
                    neg_state_q[i] <= ENP_NEG_IDLE;
                    lp_eee_q[i] <= 1'b0;
                    hw_stat_q[i] <= 1'b0;
                end else if (page[i].valid && hw_en_q[i]) begin
                    case (neg_state_q[i])
                        ENP_NEG_IDLE: begin
                            if (is_eee_msg) begin
                                neg_state_q[i] <= ENP_NEG_WAIT_CAP;
                            end
                        end
                        ENP_NEG_WAIT_CAP: begin
                            if (is_cap_page) begin
                                lp_eee_q[i] <= pw[`ENP_BIT_CAP_100];
                                hw_stat_q[i] <= cap_match;
                            end
                            neg_state_q[i] <= is_eee_msg ? ENP_NEG_WAIT_CAP : ENP_NEG_IDLE;
                        end
                        default: begin
                            neg_state_q[i] <= ENP_NEG_IDLE;
                        end
                    endcase
                end
            end

            // Hardware setting wins over a software clear in the same cycle.
            always_ff @(posedge core_clk_in or negedge reset_n_in) begin
                if (!reset_n_in) begin
                    eee_en_q[i] <= `ENP_RST_EEE_EN;
                end else if (cap_take && cap_match) begin
                    eee_en_q[i] <= 1'b1;
                end else if (wr_ctl) begin
                    eee_en_q[i] <= reg_req_in.wdata[`ENP_BIT_CTL_EEE_EN];
                end
            end

            assign eee_100_en_out[i] = eee_en_q[i];

        end
    endgenerate

endmodule // enp_next_page_regs

// >>> dv/enp_link_partner.sv
// Purpose: Behavioural link partner sending bursts of base and next page codewords.
// Assumes: Bursts change at the falling clock edge.
// Notes: Between bursts the word shows the inverse of the last one, never a stale copy.
`timescale 1ns/1ps
`include "enp_map.svh"

module enp_link_partner
    import enp_pkg::*;
(
    // Clock.
    input wire logic core_clk_in,
    // Bursts toward the block.
    output enp_burst_type burst_out
);
    logic toggle_q = 1'b0;

    initial burst_out = '0;

    // Each page goes out three times so the far end can check consistency.
    task automatic send(input logic base, input logic [15:0] word, input logic bad, input int gap);
        logic [15:0] w;
        w = word;
        if (base) begin
            toggle_q = ~word[`ENP_BIT_TOGGLE];
        end else begin
            w[`ENP_BIT_TOGGLE] = toggle_q ^ bad;
            if (!bad) toggle_q = ~toggle_q;
        end
        for (int i = 0; i < 3; i++) begin
            @(negedge core_clk_in);
            burst_out = '{1'b1, base, w};
            if (gap > 0) begin
                @(negedge core_clk_in);
                burst_out = '{1'b0, 1'b0, ~w};
                repeat (gap - 1) @(negedge core_clk_in);
            end
        end
        @(negedge core_clk_in);
        burst_out = '{1'b0, 1'b0, ~w};
    endtask
endmodule // enp_link_partner

// >>> dv/enp_regs_sva.sv
// Purpose: Concurrent checks on the ports of the EEE next page register block.
// Assumes: One clock domain; port index 0 carries back-to-back bursts in the tests.
// Notes: Bound to the design's top module at the foot of this file.
`timescale 1ns/1ps
`include "enp_map.svh"

module enp_regs_sva
    import enp_pkg::*;
#(
    parameter int NUM_PORTS = 2,
    parameter logic [10:0] EEE_MSG_CODE = 11'h00A
)
(
    // Clock and reset.
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    // Register access.
    input enp_reg_req_type reg_req_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic reg_rvalid_out,
    // Bursts and status.
    input enp_burst_type burst_in [NUM_PORTS],
    input wire logic [NUM_PORTS-1:0] ack_out,
    input wire logic [NUM_PORTS-1:0] eee_100_en_out
);
    logic [15:0] last_q;
    logic seen_q;
    wire logic [15:0] masked = burst_in[0].word & ~`ENP_ACK_MASK;
    wire logic differs = burst_in[0].valid && seen_q && (masked != (last_q & ~`ENP_ACK_MASK));
    wire logic is_sel = reg_req_in.addr == `ENP_ADDR_TBL_SEL;
    wire logic unmapped = reg_req_in.rd && !is_sel && reg_req_in.addr != `ENP_ADDR_OFFSET
        && reg_req_in.addr != `ENP_ADDR_DATA;

    // Last burst word of port index 0, kept so a differing burst can be spotted.
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            last_q <= 16'h0000;
            seen_q <= 1'b0;
        end else if (burst_in[0].valid) begin
            last_q <= burst_in[0].word;
            seen_q <= 1'b1;
        end
    end

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!reset_n_in);

    sequence s_sel_write;
        reg_req_in.wr && !reg_req_in.rd && is_sel;
    endsequence
    sequence s_three_same;
        burst_in[0].valid ##1 (burst_in[0].valid && $stable(masked))
            ##1 (burst_in[0].valid && $stable(masked));
    endsequence

    a_rd_gets_answer: assert property (reg_req_in.rd |=> reg_rvalid_out)
        else $error("read strobe got no answer one cycle later");
    a_answer_needs_read: assert property (reg_rvalid_out |-> $past(reg_req_in.rd))
        else $error("read answer without a read strobe");
    a_rdata_holds: assert property (!reg_rvalid_out |-> $stable(reg_rdata_out))
        else $error("read data moved without a read answer");
    a_unmapped_zero: assert property (unmapped |=> reg_rdata_out == 8'h00)
        else $error("unmapped address did not read zero");
    a_sel_readback: assert property (s_sel_write ##1 (reg_req_in.rd && !reg_req_in.wr && is_sel)
        |=> reg_rdata_out == $past(reg_req_in.wdata, 2))
        else $error("table select did not read back");
    a_ack_after_three: assert property (s_three_same |=> ack_out[0])
        else $error("acknowledge missing after three consistent bursts");
    a_ack_drop_differ: assert property (differs |=> !ack_out[0])
        else $error("acknowledge kept after a differing burst");
    a_ack_rise_cause: assert property ($rose(ack_out[0]) |-> $past(burst_in[0].valid))
        else $error("acknowledge rose without a burst");
    // The enable may only rise after a register write or two edges after an accepted burst.
    a_eee_rise_cause: assert property ($rose(eee_100_en_out[0]) |->
        $past(reg_req_in.wr) || $past(burst_in[0].valid, 2))
        else $error("eee enable rose without a write or a page");
endmodule // enp_regs_sva

bind enp_next_page_regs enp_regs_sva #(.NUM_PORTS(NUM_PORTS), .EEE_MSG_CODE(EEE_MSG_CODE)) u_sva (
    .core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .reg_req_in(reg_req_in),
    .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out), .burst_in(burst_in),
    .ack_out(ack_out), .eee_100_en_out(eee_100_en_out));

// >>> dv/tb_top.sv
// Purpose: Self-checking bench for the EEE next page register block.
// Assumes: Two ports, index 0 is port 3 and index 1 is port 4.
// Notes: Inputs change at the falling edge; reads are judged one cycle after the strobe.
`timescale 1ns/1ps
`include "enp_map.svh"

module tb_top
    import enp_pkg::*;
;
    logic core_clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    enp_reg_req_type req = '0;
    logic [7:0] rdata;
    logic rvalid;
    enp_burst_type burst [2];
    logic [1:0] ack;
    logic [1:0] eee_en;
    int n_fail = 0;
    int checked = 0;
    int cycles = 0;

    initial forever #2.5 core_clk_in = ~core_clk_in;

    enp_next_page_regs u_enp_next_page_regs (
        .core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .reg_req_in(req),
        .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .burst_in(burst),
        .ack_out(ack), .eee_100_en_out(eee_en));
    enp_link_partner u_lp0 (.core_clk_in(core_clk_in), .burst_out(burst[0]));
    enp_link_partner u_lp1 (.core_clk_in(core_clk_in), .burst_out(burst[1]));

    task automatic print_verdict();
        if (n_fail == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s byte %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp, input string what);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s flag %b expected %b", $time, what, got, exp);
        end
    endtask

    // A write stays on the bus until the next request replaces it, so requests run back to back.
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk_in);
        req = '{1'b1, 1'b0, a, d};
    endtask

    task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge core_clk_in);
        req = '{1'b0, 1'b1, a, 8'h00};
        @(negedge core_clk_in);
        req = '0;
        chk1(rvalid, 1'b1, "read answer");
        chk8(rdata, exp, "read data");
    endtask

    task automatic ind_rd(input logic [3:0] port, input logic [7:0] ofs, input logic [7:0] exp);
        reg_wr(`ENP_ADDR_TBL_SEL, {`ENP_TBL_EEE, 1'b0, port});
        reg_wr(`ENP_ADDR_OFFSET, ofs);
        reg_rd(`ENP_ADDR_DATA, exp);
    endtask

    task automatic t_reset_values();
        reg_rd(`ENP_ADDR_OFFSET, 8'h00);
        reg_wr(`ENP_ADDR_TBL_SEL, 8'h23);
        reg_rd(`ENP_ADDR_TBL_SEL, 8'h23);
        ind_rd(4'h3, `ENP_OFS_NP_RX_HI, 8'h00);
        ind_rd(4'h4, `ENP_OFS_NP_RX_LO, 8'h00);
        ind_rd(4'h3, `ENP_OFS_ADV_LO, 8'h02);
        ind_rd(4'h3, `ENP_OFS_CTL_LO, 8'h80);
        reg_rd(8'h55, 8'h00);
    endtask

    task automatic t_page_capture();
        u_lp0.send(1'b1, 16'h4801, 1'b0, 0);
        chk1(ack[0], 1'b1, "acknowledge after base");
        u_lp0.send(1'b0, 16'hF00A, 1'b0, 0);
        ind_rd(4'h3, `ENP_OFS_NP_RX_HI, 8'hF0);
        ind_rd(4'h3, `ENP_OFS_NP_RX_LO, 8'h0A);
        u_lp0.send(1'b0, 16'h4202, 1'b0, 0);
        ind_rd(4'h3, `ENP_OFS_NP_RX_HI, 8'h4A);
        ind_rd(4'h3, `ENP_OFS_NP_RX_LO, 8'h02);
        chk1(eee_en[0], 1'b1, "port 3 eee enable");
        chk1(eee_en[1], 1'b0, "port 4 eee enable");
        ind_rd(4'h3, `ENP_OFS_ADV_HI, 8'h02);
        ind_rd(4'h3, `ENP_OFS_CTL_LO, 8'hC1);
    endtask

    task automatic t_toggle_port4();
        u_lp1.send(1'b1, 16'h4000, 1'b0, 3);
        chk1(ack[1], 1'b1, "acknowledge after port 4 base");
        u_lp1.send(1'b0, 16'hC123, 1'b1, 3);
        chk1(ack[1], 1'b1, "acknowledge after wrong toggle");
        ind_rd(4'h4, `ENP_OFS_NP_RX_HI, 8'h00);
        u_lp1.send(1'b0, 16'hC123, 1'b0, 3);
        ind_rd(4'h4, `ENP_OFS_NP_RX_HI, 8'hC9);
        ind_rd(4'h4, `ENP_OFS_NP_RX_LO, 8'h23);
    endtask

    task automatic t_refused_access();
        reg_wr(`ENP_ADDR_TBL_SEL, 8'h23);
        reg_wr(`ENP_ADDR_OFFSET, `ENP_OFS_NP_RX_HI);
        reg_wr(`ENP_ADDR_DATA, 8'h55);
        reg_rd(`ENP_ADDR_DATA, 8'h4A);
        reg_wr(`ENP_ADDR_TBL_SEL, 8'h43);
        reg_rd(`ENP_ADDR_DATA, 8'h00);
        reg_wr(`ENP_ADDR_TBL_SEL, 8'h25);
        reg_rd(`ENP_ADDR_DATA, 8'h00);
        // Software clears the enable; the hardware status must survive the write.
        reg_wr(`ENP_ADDR_TBL_SEL, 8'h23);
        reg_wr(`ENP_ADDR_OFFSET, `ENP_OFS_CTL_LO);
        reg_wr(`ENP_ADDR_DATA, 8'h00);
        reg_rd(`ENP_ADDR_DATA, 8'h40);
        chk1(eee_en[0], 1'b0, "port 3 eee enable after clear");
        reg_wr(`ENP_ADDR_OFFSET, `ENP_OFS_ADV_LO);
        reg_wr(`ENP_ADDR_DATA, 8'h00);
        reg_rd(`ENP_ADDR_DATA, 8'h00);
    endtask

    // The whole run needs well under a thousand cycles; the ceiling leaves ample margin.
    always @(posedge core_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            n_fail = n_fail + 1;
            print_verdict();
        end
    end

    initial begin
        repeat (5) @(posedge core_clk_in);
        @(negedge core_clk_in);
        reset_n_in = 1'b1;
        t_reset_values();
        t_page_capture();
        t_toggle_port4();
        t_refused_access();
        print_verdict();
    end
endmodule // tb_top

// >>> include/enp_map.svh
// Purpose: Offsets, field positions, reset values and counts of the EEE next page block.
// Assumes: Byte-wide indirect access through a table select, an offset and a data byte.
// Notes: Definitions only.
`ifndef ENP_MAP_SVH
`define ENP_MAP_SVH

// Direct register addresses.
`define ENP_ADDR_TBL_SEL 8'h6E
`define ENP_ADDR_OFFSET 8'h6F
`define ENP_ADDR_DATA 8'hA0

// Table select fields.
`define ENP_TBL_MSB 7
`define ENP_TBL_LSB 5
`define ENP_TBL_EEE 3'h1
`define ENP_PORT_MSB 3
`define ENP_FIRST_PORT 4'h3
`define ENP_LAST_PORT 4'h4

// Indirect offsets inside one port's EEE table.
`define ENP_OFS_NP_RX_HI 8'h10
`define ENP_OFS_NP_RX_LO 8'h11
`define ENP_OFS_ADV_HI 8'h28
`define ENP_OFS_ADV_LO 8'h29
`define ENP_OFS_CTL_HI 8'h2C
`define ENP_OFS_CTL_LO 8'h2D

// Codeword bit positions.
`define ENP_BIT_MORE 15
`define ENP_BIT_ACK 14
`define ENP_BIT_MSG 13
`define ENP_BIT_COMPLY 12
`define ENP_BIT_TOGGLE 11
`define ENP_CODE_MSB 10
`define ENP_ACK_MASK 16'h4000

// Capability and control bit positions within their bytes.
`define ENP_BIT_CAP_100 1
`define ENP_BIT_CTL_HW_EN 7
`define ENP_BIT_CTL_HW_STAT 6
`define ENP_BIT_CTL_EEE_EN 0

// Reset values.
`define ENP_RST_TBL_SEL 8'h00
`define ENP_RST_OFFSET 8'h00
`define ENP_RST_NP_RX 16'h0000
`define ENP_RST_LOCAL_ADV 1'h1
`define ENP_RST_HW_EN 1'h1
`define ENP_RST_EEE_EN 1'h0

// Consistent bursts needed before a codeword is taken.
`define ENP_CONSIST_CNT 2'h3

`endif

// >>> include/enp_pkg.sv
// Purpose: Types shared by the EEE next page block.
// Assumes: Constants live in enp_map.svh.
// Notes: Structs carry grouped signals between modules.
package enp_pkg;

    // One register access from the management port.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } enp_reg_req_type;

    // One link pulse burst as decoded by the port's auto-negotiation logic.
    typedef struct packed {
        logic valid;
        logic base;
        logic [15:0] word;
    } enp_burst_type;

    // One accepted partner next page.
    typedef struct packed {
        logic valid;
        logic [15:0] word;
    } enp_page_type;

    typedef enum logic [0:0] {
        ENP_Q_BASE = 1'b0,
        ENP_Q_NEXT = 1'b1
    } enp_qual_state_type;

    typedef enum logic [0:0] {
        ENP_NEG_IDLE = 1'b0,
        ENP_NEG_WAIT_CAP = 1'b1
    } enp_neg_state_type;

endpackage
